/* File: pwtca_consts.vh */
// Register map, field positions, reset values and widths of the timer block
`ifndef PWTCA_CONSTS_VH
`define PWTCA_CONSTS_VH

// Byte offsets on the register bus
`define PWTCA_OFS_GEN_CTRL 8'h00
`define PWTCA_OFS_BUF_EN 8'h04
`define PWTCA_OFS_PERIOD 8'h08
`define PWTCA_OFS_COUNT 8'h0c
`define PWTCA_OFS_ADC_BUF_A 8'h10
`define PWTCA_OFS_ADC_BUF_B 8'h14
`define PWTCA_OFS_ADC_ACT_A 8'h18
`define PWTCA_OFS_ADC_ACT_B 8'h1c
`define PWTCA_OFS_FINE_CTRL 8'h20
`define PWTCA_OFS_FINE_DLY0 8'h24
`define PWTCA_OFS_STATUS 8'h34
`define PWTCA_OFS_CLEAR 8'h38

// General control fields
`define PWTCA_CTRL_RUN 0
`define PWTCA_CTRL_DOWN 1
`define PWTCA_CTRL_TRI 16
`define PWTCA_CTRL_PSC_HI 26
`define PWTCA_CTRL_PSC_LO 23
`define PWTCA_CTRL_WMASK 32'h07810003

// Buffer enable fields
`define PWTCA_BEN_TTA_HI 25
`define PWTCA_BEN_TTA_LO 24
`define PWTCA_BEN_TTB_HI 29
`define PWTCA_BEN_TTB_LO 28
`define PWTCA_BEN_WMASK 32'h33000000

// Transfer timing codes
`define PWTCA_XFER_NONE 2'b00
`define PWTCA_XFER_TROUGH 2'b01
`define PWTCA_XFER_CREST 2'b10
`define PWTCA_XFER_BOTH 2'b11

// Prescaler codes
`define PWTCA_PSC_PROHIB 4'hb
`define PWTCA_PSC_MAXDIV 4'ha
`define PWTCA_PSC_CNT_W 10

// Widths and reset values
`define PWTCA_CNT_W 16
`define PWTCA_PERIOD_RST 16'hffff
`define PWTCA_FINE_CH 4
`define PWTCA_FINE_BYPASS_RST 4'hf
`define PWTCA_FINE_STEPS 32
`define PWTCA_FINE_TAP_W 5
`define PWTCA_COARSE_W 3
`define PWTCA_HIST_LEN 8

`endif

/* File: pwtca_prescaler.v */
// Counting clock selection: binary divider or external trigger edges
`timescale 1ns/1ps
`include "pwtca_consts.vh"
module pwtca_prescaler (
    input wire clk_i,
    input wire rst_i,
    input wire [3:0] count_clock_prescale_sel_i,
    input wire ext_trigger_in_a_i,
    input wire ext_trigger_in_b_i,
    input wire ext_trigger_in_c_i,
    input wire ext_trigger_in_d_i,
    output wire count_tick_o,
    output wire [3:0] active_sel_o
);
    reg [`PWTCA_PSC_CNT_W-1:0] div_cnt_ff;
    reg [3:0] ext_prev_ff;
    reg [3:0] active_sel_ff;
    wire [3:0] ext_now;
    wire [3:0] ext_rise;

    // Tick for a given selection code
    function tick_of;
        input [3:0] sel;
        input [`PWTCA_PSC_CNT_W-1:0] cnt;
        input [3:0] rise;
        reg [`PWTCA_PSC_CNT_W-1:0] mask;
        begin
            mask = ~({`PWTCA_PSC_CNT_W{1'b1}} << sel);
            if (sel <= `PWTCA_PSC_MAXDIV) begin
                tick_of = ((cnt & mask) == mask);
            end else if (sel == `PWTCA_PSC_PROHIB) begin
                tick_of = 1'b0;
            end else begin
                tick_of = rise[sel[1:0]];
            end
        end
    endfunction

    assign ext_now = {ext_trigger_in_d_i, ext_trigger_in_c_i,
                      ext_trigger_in_b_i, ext_trigger_in_a_i};
    assign ext_rise = ext_now & ~ext_prev_ff;
    assign count_tick_o = tick_of(active_sel_ff, div_cnt_ff, ext_rise);
    assign active_sel_o = active_sel_ff;

    // Free divider, trigger edge history, selection taken at a tick or while code 1011 is active
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_ff <= {`PWTCA_PSC_CNT_W{1'b0}};
            ext_prev_ff <= 4'h0;
            active_sel_ff <= 4'h0;
        end else begin
            div_cnt_ff <= div_cnt_ff + {{(`PWTCA_PSC_CNT_W-1){1'b0}}, 1'b1};
            ext_prev_ff <= ext_now;
            if (count_tick_o || active_sel_ff == `PWTCA_PSC_PROHIB) begin
                active_sel_ff <= count_clock_prescale_sel_i;
            end
        end
    end
endmodule

/* File: pwtca_fine_edge.v */
// Fine edge adjust stage for complementary waveforms of four channels
`timescale 1ns/1ps
`include "pwtca_consts.vh"
module pwtca_fine_edge (
    input wire clk_i,
    input wire rst_i,
    input wire [3:0] pwm_p_i,
    input wire [3:0] pwm_n_i,
    input wire [3:0] bypass_i,
    input wire [31:0] rise_dly_i,
    input wire [31:0] fall_dly_i,
    output wire [3:0] fine_p_o,
    output wire [3:0] fine_n_o,
    output wire [39:0] fine_tap_o
);
    wire [7:0] wave_in;
    wire [7:0] wave_out;

    assign wave_in = {pwm_n_i, pwm_p_i};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_wave
            reg [`PWTCA_HIST_LEN-1:0] hist_ff;
            reg out_ff;
            reg [`PWTCA_FINE_TAP_W-1:0] tap_ff;
            wire [7:0] rdly;
            wire [7:0] fdly;
            wire [`PWTCA_HIST_LEN:0] line;
            assign rdly = rise_dly_i[(gi%4)*8 +: 8];
            assign fdly = fall_dly_i[(gi%4)*8 +: 8];
            assign line = {hist_ff, wave_in[gi]};
            // Rise and fall edges delayed separately, coarse part here
            always @(posedge clk_i) begin
                if (rst_i) begin
                    hist_ff <= {`PWTCA_HIST_LEN{1'b0}};
                    out_ff <= 1'b0;
                    tap_ff <= {`PWTCA_FINE_TAP_W{1'b0}};
                end else begin
                    hist_ff <= line[`PWTCA_HIST_LEN-1:0];
                    if (out_ff) begin
                        out_ff <= line[fdly[7:5]];
                    end else begin
                        out_ff <= line[rdly[7:5]];
                    end
                    // Fine tap in 1/32 clock steps for the next edge
                    tap_ff <= out_ff ? fdly[4:0] : rdly[4:0];
                end
            end
            assign wave_out[gi] = bypass_i[gi%4] ? wave_in[gi] : out_ff;
            assign fine_tap_o[gi*5 +: 5] = tap_ff;
        end
    endgenerate

    assign fine_p_o = wave_out[3:0];
    assign fine_n_o = wave_out[7:4];
endmodule

/* File: pwtca_top.v */
// Timer channel with clock select, A/D trigger buffers and fine edge stage
`timescale 1ns/1ps
`include "pwtca_consts.vh"
module pwtca_top (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output wire [31:0] dat_o,
    output wire ack_o,
    input wire ext_trigger_in_a_i,
    input wire ext_trigger_in_b_i,
    input wire ext_trigger_in_c_i,
    input wire ext_trigger_in_d_i,
    input wire [3:0] pwm_p_i,
    input wire [3:0] pwm_n_i,
    output wire [15:0] count_o,
    output wire [15:0] adc_trig_compare_a_o,
    output wire [15:0] adc_trig_compare_b_o,
    output wire adc_trig_xfer_a_o,
    output wire adc_trig_xfer_b_o,
    output wire [3:0] fine_p_o,
    output wire [3:0] fine_n_o,
    output wire [39:0] fine_tap_o
);
    reg ack_ff;
    reg [31:0] dat_ff;
    reg [31:0] ctrl_ff;
    reg [31:0] bufen_ff;
    reg [15:0] period_ff;
    reg [15:0] cnt_ff;
    reg down_ff;
    reg [15:0] cmp_a_buf_ff;
    reg [15:0] cmp_b_buf_ff;
    reg [15:0] cmp_a_act_ff;
    reg [15:0] cmp_b_act_ff;
    reg xfer_a_ff;
    reg xfer_b_ff;
    reg [3:0] fine_bypass_ff;
    reg [15:0] fine_dly_ff [0:3];
    reg [15:0] nxt_cnt;
    reg nxt_down;
    reg crest;
    reg trough;
    reg saw_event;
    reg [31:0] rd_data;
    wire req;
    wire wr_go;
    wire clr_go;
    wire tick;
    wire run;
    wire tri_mode;
    wire [3:0] active_sel;
    wire [31:0] rise_dly;
    wire [31:0] fall_dly;
    wire xfer_a;
    wire xfer_b;

    // Byte lane merge of a write into an old value
    function [31:0] wb_merge;
        input [31:0] old;
        input [31:0] val;
        input [3:0] sel;
        integer k;
        begin
            wb_merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (sel[k]) begin
                    wb_merge[k*8 +: 8] = val[k*8 +: 8];
                end
            end
        end
    endfunction

    // Merge of a write into a 16-bit register
    function [15:0] wb_lo16;
        input [15:0] old;
        input [31:0] val;
        input [3:0] sel;
        begin
            wb_lo16 = {sel[1] ? val[15:8] : old[15:8],
                       sel[0] ? val[7:0] : old[7:0]};
        end
    endfunction

    // Buffer transfer decision for one timing field
    function xfer_of;
        input [1:0] timing;
        input tri_m;
        input at_crest;
        input at_trough;
        input saw_ev;
        begin
            if (timing == `PWTCA_XFER_NONE) begin
                xfer_of = 1'b0;
            end else if (tri_m) begin
                xfer_of = (timing[0] & at_trough) | (timing[1] & at_crest);
            end else begin
                xfer_of = saw_ev;
            end
        end
    endfunction

    assign req = cyc_i & stb_i;
    assign wr_go = req & we_i & ack_ff;
    assign clr_go = wr_go & (adr_i == `PWTCA_OFS_CLEAR) & sel_i[0] & dat_i[0];
    assign ack_o = ack_ff;
    assign dat_o = dat_ff;
    assign run = ctrl_ff[`PWTCA_CTRL_RUN];
    assign tri_mode = ctrl_ff[`PWTCA_CTRL_TRI];

    // Counting clock source
    pwtca_prescaler u_psc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .count_clock_prescale_sel_i(
            ctrl_ff[`PWTCA_CTRL_PSC_HI:`PWTCA_CTRL_PSC_LO]),
        .ext_trigger_in_a_i(ext_trigger_in_a_i),
        .ext_trigger_in_b_i(ext_trigger_in_b_i),
        .ext_trigger_in_c_i(ext_trigger_in_c_i),
        .ext_trigger_in_d_i(ext_trigger_in_d_i),
        .count_tick_o(tick),
        .active_sel_o(active_sel)
    );

    // Next counter value and crest, trough, overflow or underflow events
    always @* begin
        nxt_cnt = cnt_ff;
        nxt_down = down_ff;
        crest = 1'b0;
        trough = 1'b0;
        saw_event = 1'b0;
        if (clr_go) begin
            nxt_cnt = 16'h0000;
            nxt_down = ctrl_ff[`PWTCA_CTRL_DOWN] & ~tri_mode;
            saw_event = 1'b1;
        end else if (run && tick) begin
            if (tri_mode) begin
                if (down_ff) begin
                    if (cnt_ff == 16'h0000) begin
                        trough = 1'b1;
                        nxt_down = 1'b0;
                        nxt_cnt = 16'h0001;
                    end else begin
                        nxt_cnt = cnt_ff - 16'h0001;
                    end
                end else if (cnt_ff >= period_ff) begin
                    crest = 1'b1;
                    nxt_down = 1'b1;
                    nxt_cnt = cnt_ff - 16'h0001;
                end else begin
                    nxt_cnt = cnt_ff + 16'h0001;
                end
            end else if (ctrl_ff[`PWTCA_CTRL_DOWN]) begin
                nxt_down = 1'b1;
                if (cnt_ff == 16'h0000) begin
                    nxt_cnt = period_ff;
                    saw_event = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end else begin
                nxt_down = 1'b0;
                if (cnt_ff >= period_ff) begin
                    nxt_cnt = 16'h0000;
                    saw_event = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff + 16'h0001;
                end
            end
        end
    end

    assign xfer_a = xfer_of(bufen_ff[`PWTCA_BEN_TTA_HI:`PWTCA_BEN_TTA_LO],
                            tri_mode, crest, trough, saw_event);
    assign xfer_b = xfer_of(bufen_ff[`PWTCA_BEN_TTB_HI:`PWTCA_BEN_TTB_LO],
                            tri_mode, crest, trough, saw_event);

    // Counter state and buffer to active compare transfers
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 16'h0000;
            down_ff <= 1'b0;
            cmp_a_act_ff <= 16'h0000;
            cmp_b_act_ff <= 16'h0000;
            xfer_a_ff <= 1'b0;
            xfer_b_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            down_ff <= nxt_down;
            xfer_a_ff <= xfer_a;
            xfer_b_ff <= xfer_b;
            if (xfer_a) begin
                cmp_a_act_ff <= cmp_a_buf_ff;
            end
            if (xfer_b) begin
                cmp_b_act_ff <= cmp_b_buf_ff;
            end
        end
    end

    // Register writes, taken at the edge where ack is high
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= 32'h00000000;
            bufen_ff <= 32'h00000000;
            period_ff <= `PWTCA_PERIOD_RST;
            cmp_a_buf_ff <= 16'h0000;
            cmp_b_buf_ff <= 16'h0000;
            fine_bypass_ff <= `PWTCA_FINE_BYPASS_RST;
            fine_dly_ff[0] <= 16'h0000;
            fine_dly_ff[1] <= 16'h0000;
            fine_dly_ff[2] <= 16'h0000;
            fine_dly_ff[3] <= 16'h0000;
        end else if (wr_go) begin
            case (adr_i)
                `PWTCA_OFS_GEN_CTRL: begin
                    ctrl_ff <= wb_merge(ctrl_ff, dat_i, sel_i)
                               & `PWTCA_CTRL_WMASK;
                end
                `PWTCA_OFS_BUF_EN: begin
                    bufen_ff <= wb_merge(bufen_ff, dat_i, sel_i)
                                & `PWTCA_BEN_WMASK;
                end
                `PWTCA_OFS_PERIOD: begin
                    period_ff <= wb_lo16(period_ff, dat_i, sel_i);
                end
                `PWTCA_OFS_ADC_BUF_A: begin
                    cmp_a_buf_ff <= wb_lo16(cmp_a_buf_ff, dat_i, sel_i);
                end
                `PWTCA_OFS_ADC_BUF_B: begin
                    cmp_b_buf_ff <= wb_lo16(cmp_b_buf_ff, dat_i, sel_i);
                end
                `PWTCA_OFS_FINE_CTRL: begin
                    if (sel_i[0]) begin
                        fine_bypass_ff <= dat_i[3:0];
                    end
                end
                default: begin
                    if (adr_i[7:4] == 4'h2 || adr_i[7:4] == 4'h3) begin
                        if (adr_i >= `PWTCA_OFS_FINE_DLY0 &&
                            adr_i < `PWTCA_OFS_STATUS &&
                            adr_i[1:0] == 2'b00) begin
                            fine_dly_ff[adr_i[3:2] - 2'b01] <=
                                wb_lo16(fine_dly_ff[adr_i[3:2] - 2'b01],
                                    dat_i, sel_i);
                        end
                    end
                end
            endcase
        end
    end

    // Read multiplexer; unmapped offsets read as zero
    always @* begin
        case (adr_i)
            `PWTCA_OFS_GEN_CTRL: rd_data = ctrl_ff;
            `PWTCA_OFS_BUF_EN: rd_data = bufen_ff;
            `PWTCA_OFS_PERIOD: rd_data = {16'h0000, period_ff};
            `PWTCA_OFS_COUNT: rd_data = {16'h0000, cnt_ff};
            `PWTCA_OFS_ADC_BUF_A: rd_data = {16'h0000, cmp_a_buf_ff};
            `PWTCA_OFS_ADC_BUF_B: rd_data = {16'h0000, cmp_b_buf_ff};
            `PWTCA_OFS_ADC_ACT_A: rd_data = {16'h0000, cmp_a_act_ff};
            `PWTCA_OFS_ADC_ACT_B: rd_data = {16'h0000, cmp_b_act_ff};
            `PWTCA_OFS_FINE_CTRL: rd_data = {28'h0000000, fine_bypass_ff};
            8'h24: rd_data = {16'h0000, fine_dly_ff[0]};
            8'h28: rd_data = {16'h0000, fine_dly_ff[1]};
            8'h2c: rd_data = {16'h0000, fine_dly_ff[2]};
            8'h30: rd_data = {16'h0000, fine_dly_ff[3]};
            `PWTCA_OFS_STATUS: rd_data = {27'h0000000, active_sel, down_ff};
            default: rd_data = 32'h00000000;
        endcase
    end

    // One wait state slave: ack in the cycle after the request
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h00000000;
        end else begin
            ack_ff <= req & ~ack_ff;
            if (req && !ack_ff && !we_i) begin
                dat_ff <= rd_data;
            end
        end
    end

    // Edge delays packed per channel: low byte rise, high byte fall
    genvar gc;
    generate
        for (gc = 0; gc < `PWTCA_FINE_CH; gc = gc + 1) begin : g_dly
            assign rise_dly[gc*8 +: 8] = fine_dly_ff[gc][7:0];
            assign fall_dly[gc*8 +: 8] = fine_dly_ff[gc][15:8];
        end
    endgenerate

    // Fine edge stage on the complementary outputs
    pwtca_fine_edge u_fine (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pwm_p_i(pwm_p_i),
        .pwm_n_i(pwm_n_i),
        .bypass_i(fine_bypass_ff),
        .rise_dly_i(rise_dly),
        .fall_dly_i(fall_dly),
        .fine_p_o(fine_p_o),
        .fine_n_o(fine_n_o),
        .fine_tap_o(fine_tap_o)
    );

    assign count_o = cnt_ff;
    assign adc_trig_compare_a_o = cmp_a_act_ff;
    assign adc_trig_compare_b_o = cmp_b_act_ff;
    assign adc_trig_xfer_a_o = xfer_a_ff;
    assign adc_trig_xfer_b_o = xfer_b_ff;
endmodule

/* File: pwtca_sva.sv */
// Assertion checker for the timer block, bound to its top module
`timescale 1ns/1ps
`include "pwtca_consts.vh"
module pwtca_checker (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [31:0] dat_i,
    input wire ack_o,
    input wire [3:0] pwm_p_i,
    input wire [3:0] pwm_n_i,
    input wire [15:0] count_o,
    input wire adc_trig_xfer_a_o,
    input wire adc_trig_xfer_b_o,
    input wire [3:0] fine_p_o,
    input wire [3:0] fine_n_o
);
    logic [31:0] ctrl_ff;
    logic [31:0] ben_ff;
    logic [3:0] byp_ff;
    wire wr = cyc_i && stb_i && we_i && ack_o;
    wire [3:0] psc = ctrl_ff[26:23];
    wire saw_up = ctrl_ff[0] && !ctrl_ff[1] && !ctrl_ff[16];
    wire [1:0] tta = ben_ff[25:24];
    wire [1:0] ttb = ben_ff[29:28];
    // Shadow of the fields software last wrote, taken at the ack edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= 32'h0;
            ben_ff <= 32'h0;
            byp_ff <= 4'hf;
        end else if (wr && adr_i == `PWTCA_OFS_GEN_CTRL) begin
            ctrl_ff <= dat_i;
        end else if (wr && adr_i == `PWTCA_OFS_BUF_EN) begin
            ben_ff <= dat_i;
        end else if (wr && adr_i == `PWTCA_OFS_FINE_CTRL) begin
            byp_ff <= dat_i[3:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus answers one cycle after a taken request, as a single pulse
    chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack late");
    chk_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    // Timing code 00 never transfers
    chk_off_a_quiet: assert property (
        tta == 2'b00 && $past(tta) == 2'b00 && $past(tta, 2) == 2'b00
        |-> !adc_trig_xfer_a_o) else $error("A transfer while off");
    chk_off_b_quiet: assert property (
        ttb == 2'b00 && $past(ttb) == 2'b00 && $past(ttb, 2) == 2'b00
        |-> !adc_trig_xfer_b_o) else $error("B transfer while off");
    // Sawtooth up: a wrap or clear to zero transfers
    chk_wrap_xfer_a: assert property (
        saw_up && tta != 2'b00 && $past(saw_up && tta != 2'b00) &&
        count_o == 16'h0 && $past(count_o) != 16'h0
        |-> ##[0:1] adc_trig_xfer_a_o) else $error("A wrap lost");
    chk_wrap_xfer_b: assert property (
        saw_up && ttb != 2'b00 && $past(saw_up && ttb != 2'b00) &&
        count_o == 16'h0 && $past(count_o) != 16'h0
        |-> ##[0:1] adc_trig_xfer_b_o) else $error("B wrap lost");
    chk_bypass_pass: assert property (
        byp_ff == 4'hf && $past(byp_ff) == 4'hf
        |-> fine_p_o == pwm_p_i && fine_n_o == pwm_n_i)
        else $error("bypass altered waveform");
    chk_psc_halt: assert property (
        psc == 4'hb && $past(psc, 4) == 4'hb && !$past(cyc_i)
        |-> $stable(count_o)) else $error("count moved on code 1011");
    chk_div_two: assert property (
        saw_up && psc == 4'h1 && $past(psc, 4) == 4'h1 && !$past(cyc_i)
        && $changed(count_o) |=> $stable(count_o))
        else $error("divide by two stepped twice");
    cover property (adc_trig_xfer_a_o && ctrl_ff[16]);
    cover property (adc_trig_xfer_b_o && saw_up);
    cover property (ack_o && !we_i);
endmodule

bind pwtca_top pwtca_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o),
    .pwm_p_i(pwm_p_i), .pwm_n_i(pwm_n_i), .count_o(count_o),
    .adc_trig_xfer_a_o(adc_trig_xfer_a_o),
    .adc_trig_xfer_b_o(adc_trig_xfer_b_o),
    .fine_p_o(fine_p_o), .fine_n_o(fine_n_o)
);

/* File: pwtca_far_end.sv */
// Far-side model: trigger lines and complementary waveform source
`timescale 1ns/1ps
module pwtca_far_end (
    input wire clk_i,
    input wire rst_i,
    output logic [3:0] ext_trig_o = 4'h0,
    output logic [3:0] pwm_p_o,
    output logic [3:0] pwm_n_o
);
    logic [3:0] ph_ff = 4'h0;
    // Phase counter, wraps every twelve cycles
    always @(posedge clk_i) begin
        if (rst_i || ph_ff == 4'hb) begin
            ph_ff <= 4'h0;
        end else begin
            ph_ff <= ph_ff + 4'h1;
        end
    end
    // Four complementary pairs, two cycles apart
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pwm_p_o[i] = ({1'b0, ph_ff} + 5'(2 * i)) % 5'd12 < 5'd6;
            pwm_n_o[i] = !pwm_p_o[i];
        end
    end
    // Edges on one trigger line, as the output enable unit passes them
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            @(posedge clk_i);
            ext_trig_o[idx] <= 1'b1;
            repeat (2) @(posedge clk_i);
            ext_trig_o[idx] <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask
endmodule

/* File: pwtca_tb.sv */
// Self-checking bench for the timer block
`timescale 1ns/1ps
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0;
    wire [31:0] dat_o;
    wire ack_o;
    wire [3:0] trig;
    wire [3:0] pwm_p;
    wire [3:0] pwm_n;
    wire [15:0] count_o;
    wire xa;
    wire xb;
    wire [3:0] fine_p;
    wire [3:0] fine_n;
    wire [39:0] tap;
    wire [15:0] cmp_a, cmp_b;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;

    always #12.5 clk_i = !clk_i;

    pwtca_top u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .ext_trigger_in_a_i(trig[0]),
        .ext_trigger_in_b_i(trig[1]), .ext_trigger_in_c_i(trig[2]),
        .ext_trigger_in_d_i(trig[3]), .pwm_p_i(pwm_p), .pwm_n_i(pwm_n),
        .count_o(count_o), .adc_trig_compare_a_o(cmp_a),
        .adc_trig_compare_b_o(cmp_b), .adc_trig_xfer_a_o(xa),
        .adc_trig_xfer_b_o(xb), .fine_p_o(fine_p), .fine_n_o(fine_n),
        .fine_tap_o(tap)
    );
    pwtca_far_end u_far (.clk_i(clk_i), .rst_i(rst_i), .ext_trig_o(trig),
        .pwm_p_o(pwm_p), .pwm_n_o(pwm_n));

    // Compare one value and count the outcome
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Classic single bus cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, q);
    endtask

    // Cycles between the second and third count steps
    task automatic meas(output int k);
        logic [15:0] v;
        k = 0;
        repeat (3) begin
            v = count_o;
            k = 0;
            do begin
                @(posedge clk_i);
                k++;
            end while (count_o === v && k < 3000);
        end
    endtask

    // Cycles from an input edge on channel 0 to the same output edge
    task automatic lag(input logic lvl, output int k);
        k = 0;
        while (pwm_p[0] === lvl) @(posedge clk_i);
        while (pwm_p[0] !== lvl) @(posedge clk_i);
        while (fine_p[0] !== lvl && k < 20) begin
            @(posedge clk_i);
            k++;
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Cut a hang short
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            $display("timeout");
            conclude();
        end
    end

    initial begin
        logic [31:0] q;
        int k;
        int na;
        int nb;
        logic prev;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values and an unmapped offset
        rd(8'h08, q);
        chk("period", q, 32'hffff);
        rd(8'h20, q);
        chk("bypass", q, 32'hf);
        rd(8'h3c, q);
        chk("unmapped", q, 32'h0);
        $display("test reset done");
        // Every divide code, timed between count steps
        for (int c = 0; c < 11; c++) begin
            wr(8'h00, 32'h1 | (c << 23));
            meas(k);
            chk("divide", k, 1 << c);
        end
        $display("test prescale done");
        // Code 1011 written on purpose: counting halts after a clear
        wr(8'h00, 32'h1);
        meas(k);
        wr(8'h00, 32'h1 | (32'hb << 23));
        wr(8'h38, 32'h1);
        repeat (40) @(posedge clk_i);
        rd(8'h0c, q);
        chk("halted", q, 32'h0);
        $display("test prohibited done");
        // One trigger line counts, the other three are ignored
        for (int c = 0; c < 4; c++) begin
            wr(8'h00, 32'h1 | ((12 + c) << 23));
            for (int t = 0; t < 4; t++) u_far.pulse(t, 1);
            wr(8'h38, 32'h1);
            for (int t = 0; t < 4; t++) u_far.pulse(t, t == c ? c + 2 : 1);
            repeat (8) @(posedge clk_i);
            rd(8'h0c, q);
            chk("trig_count", q, c + 2);
            rd(8'h34, q);
            chk("active_sel", q[4:1], 12 + c);
        end
        $display("test triggers done");
        // Sawtooth transfers up, down and on clear
        wr(8'h00, 32'h0);
        u_far.pulse(3, 1);
        wr(8'h08, 32'h4);
        wr(8'h10, 32'h1234);
        wr(8'h14, 32'h5678);
        wr(8'h04, 32'h01000000);
        wr(8'h38, 32'h1);
        wr(8'h00, 32'h1);
        repeat (12) @(posedge clk_i);
        rd(8'h18, q);
        chk("act_a", q, 32'h1234);
        rd(8'h1c, q);
        chk("act_b_off", q, 32'h0);
        wr(8'h04, 32'h22000000);
        repeat (12) @(posedge clk_i);
        rd(8'h1c, q);
        chk("act_b", q, 32'h5678);
        chk("cmp_ab", {cmp_a, cmp_b}, 32'h12345678);
        wr(8'h10, 32'habc);
        wr(8'h00, 32'h3);
        repeat (12) @(posedge clk_i);
        rd(8'h18, q);
        chk("act_a_down", q, 32'habc);
        wr(8'h00, 32'h2);
        wr(8'h10, 32'hdef);
        wr(8'h38, 32'h1);
        repeat (3) @(posedge clk_i);
        rd(8'h18, q);
        chk("act_a_clear", q, 32'hdef);
        $display("test sawtooth done");
        // Triangle: each code on A, its mirror on B, over two periods
        wr(8'h08, 32'h8);
        wr(8'h00, 32'h10001);
        for (int c = 0; c < 4; c++) begin
            wr(8'h04, (c << 24) | ((3 - c) << 28));
            repeat (4) @(posedge clk_i);
            na = 0;
            nb = 0;
            repeat (32) begin
                @(posedge clk_i);
                nb += (xb === 1'b1);
                if (xa === 1'b1) begin
                    na++;
                    if (c % 3) chk("side", count_o > 16'h4, c == 2);
                end
            end
            chk("xfer_a", na, 2 * (c % 2 + c / 2));
            chk("xfer_b", nb, 2 * ((3 - c) % 2 + (3 - c) / 2));
        end
        $display("test triangle done");
        // Fine stage on channel 0, the rest bypassed
        wr(8'h24, 32'h4520);
        wr(8'h20, 32'he);
        lag(1'b1, na);
        lag(1'b0, nb);
        chk("lag_diff", nb - na, 1);
        prev = fine_p[0];
        repeat (24) begin
            @(posedge clk_i);
            if (fine_p[0] === prev) chk("tap", tap[4:0], 5 * prev);
            prev = fine_p[0];
            chk("bypass_ch", {fine_p[3:1], fine_n[3:1]},
                {pwm_p[3:1], pwm_n[3:1]});
        end
        $display("test fine edge done");
        conclude();
    end
endmodule
